// [design/pam_model.sv]
`timescale 1ns/1ps
module pam_model (
	input  wire logic        ref_clk,    // Clock, 20 MHz
	input  wire logic        rst_b,      // Async reset
	input  wire logic        hsel,       // AHB select
	input  wire logic [31:0] haddr,      // AHB address
	input  wire logic [1:0]  htrans,     // AHB transfer type
	input  wire logic        hwrite,     // AHB write
	input  wire logic [2:0]  hsize,      // AHB size
	input  wire logic [31:0] hwdata,     // AHB write data
	input  wire logic        hready,     // AHB ready
	output logic [31:0]      hrdata,     // AHB read data
	output logic             hreadyout,  // AHB slave ready
	output logic             hresp,      // AHB response
	input  wire logic        coef_valid, // Coefficient offered
	input  wire logic [15:0] coef_data,  // Zig-zag coefficient
	output logic             coef_ready, // Coefficient taken
	output logic             dec_valid,  // Decision pending
	output logic [7:0]       dec_ctx,    // Bin index
	output logic             dec_fixed,  // Fixed estimate request
	output logic             dec_bit,    // Decision value
	output pam_pkg::pam_area_t dec_area, // Statistics area
	output logic [1:0]       dec_table,  // Table set
	input  wire logic        dec_ready   // Engine accepts
);
	typedef enum logic [3:0] {
		ST_LOAD, ST_DC_ZERO, ST_DC_SIGN, ST_DC_REF, ST_EOB,
		ST_ZSCAN, ST_SIGN, ST_SZ0, ST_LOG, ST_MAG
	} pam_state_t;

	pam_pkg::pam_mode_t mode;
	logic [1:0]  tbl;
	logic        restart;
	logic [5:0]  ss;
	logic [5:0]  se;
	logic [3:0]  al;
	logic [5:0]  kx;
	logic [3:0]  dc_l;
	logic [3:0]  dc_u;

	pam_state_t  state_q;
	pam_state_t  state_d;
	logic [6:0]  k_q;
	logic [6:0]  k_d;
	logic [16:0] m_q;
	logic [16:0] m_d;
	logic [7:0]  s_q;
	logic [7:0]  s_d;
	logic [16:0] sz_q;
	logic [16:0] sz_d;
	logic [5:0]  ld_cnt_q;
	logic [6:0]  eob_q;
	logic [6:0]  previous_band_end_q;
	logic [16:0] dc_abs_q;
	logic        dc_neg_q;
	logic        dc_ref_q;
	logic [7:0]  dc_s0_q;
	logic [6:0]  last_eob_q;
	logic [15:0] blk_cnt_q;
	logic [16:0] abs_q [pam_pkg::BAND_LEN];
	logic        sgn_q [pam_pkg::BAND_LEN];
	logic signed [15:0] pred_q [pam_pkg::NUM_TBL];
	logic [7:0]  da_ctx_q [pam_pkg::NUM_TBL];
	logic        req;
	logic        d_fix;
	logic        d_bit;
	logic [7:0]  d_ctx;

	pam_dec_if dp ();

	pam_ahb_regs u_regs (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.mode      (mode),
		.tbl       (tbl),
		.restart   (restart),
		.ss        (ss),
		.se        (se),
		.al        (al),
		.kx        (kx),
		.dc_l      (dc_l),
		.dc_u      (dc_u),
		.busy      (state_q != ST_LOAD),
		.last_eob  (last_eob_q),
		.blk_cnt   (blk_cnt_q)
	);

	pam_dec_port u_port (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.dp        (dp),
		.dec_valid (dec_valid),
		.dec_ctx   (dec_ctx),
		.dec_fixed (dec_fixed),
		.dec_bit   (dec_bit),
		.dec_area  (dec_area),
		.dec_table (dec_table),
		.dec_ready (dec_ready)
	);

	// Mode decode
	wire is_dc  = (mode == pam_pkg::PAM_DC_FIRST) || (mode == pam_pkg::PAM_DC_REFINE);
	wire is_ref = (mode == pam_pkg::PAM_AC_REFINE);
	wire adv    = req && dp.free;

	// Load path: point transform of the incoming coefficient
	wire               coef_take = coef_valid && coef_ready;
	wire signed [15:0] coef_s    = coef_data;
	wire signed [16:0] coef_x    = 17'(coef_s);
	wire [16:0]        coef_abs  = coef_x[16] ? 17'(-coef_x) : coef_x;
	wire [16:0]        pt_abs    = coef_abs >> al;
	wire [5:0]         ld_k      = ss + ld_cnt_q;
	wire               ld_last   = ld_k >= se;
	wire               ld_first  = (ld_cnt_q == 6'h00);
	wire               pt_nz     = |pt_abs;
	wire               pt_hist   = |pt_abs[16:1];
	wire [6:0]         ld_k1     = {1'b0, ld_k} + 7'h01;

	// DC difference and its conditioning class
	wire signed [15:0] dc_pt    = coef_s >>> al;
	// A restart in the take cycle must already see cleared state
	wire signed [15:0] dc_pred  = restart ? 16'sh0 : pred_q[tbl];
	wire signed [16:0] dc_diff  = 17'(dc_pt) - 17'(dc_pred);
	wire [16:0]        dc_dabs  = dc_diff[16] ? 17'(-dc_diff) : dc_diff;
	wire [16:0]        lo_lim   = (dc_l == 4'h0) ? 17'h0 : (17'h1 << (dc_l - 4'h1));
	wire [16:0]        hi_lim   = 17'h1 << dc_u;
	wire [7:0]         dc_class = (dc_dabs <= lo_lim) ? pam_pkg::DC_S0_ZERO :
		(dc_dabs <= hi_lim) ? (dc_diff[16] ? pam_pkg::DC_S0_SNEG : pam_pkg::DC_S0_SPOS) :
		(dc_diff[16] ? pam_pkg::DC_S0_LNEG : pam_pkg::DC_S0_LPOS);

	// Coding path
	wire [5:0]  k6        = k_q[5:0];
	wire [16:0] cur_abs   = abs_q[k6];
	wire        cur_sgn   = sgn_q[k6];
	wire        cur_hist  = |cur_abs[16:1];
	wire        band_done = k_q > {1'b0, se};
	wire [7:0]  km1       = 8'(k_q) - 8'h01;
	wire [7:0]  se_ctx    = (km1 << 1) + km1;
	wire        sz_ge     = {1'b0, sz_q} >= {m_q, 1'b0};
	wire [7:0]  x1_ctx    = (k_q <= {1'b0, kx}) ? pam_pkg::AC_X1_LO : pam_pkg::AC_X1_HI;
	wire [7:0]  dc_sz_ofs = dc_neg_q ? pam_pkg::DC_SZ_NEG_OFS : pam_pkg::DC_SZ_POS_OFS;

	assign dp.req   = req;
	assign dp.ctx   = d_ctx;
	assign dp.fixed = d_fix;
	assign dp.bit_v = d_bit;
	assign dp.tbl   = tbl;
	assign dp.area  = d_fix ? pam_pkg::PAM_AREA_FIXED : is_dc ? pam_pkg::PAM_AREA_DC :
		is_ref ? pam_pkg::PAM_AREA_ACR : pam_pkg::PAM_AREA_AC;

	// One decision per step, in encoder order so a decoder can walk it back
	always_comb begin
		state_d = state_q;
		k_d     = k_q;
		m_d     = m_q;
		s_d     = s_q;
		sz_d    = sz_q;
		req     = 1'b0;
		d_fix   = 1'b0;
		d_bit   = 1'b0;
		d_ctx   = 8'h00;
		unique case (state_q)
			ST_LOAD: begin
				if (coef_take) begin
					if (mode == pam_pkg::PAM_DC_FIRST) begin
						state_d = ST_DC_ZERO;
					end else if (mode == pam_pkg::PAM_DC_REFINE) begin
						state_d = ST_DC_REF;
					end else if (ld_last) begin
						state_d = ST_EOB;
						k_d     = {1'b0, ss};
					end
				end
			end
			ST_DC_ZERO: begin
				req   = 1'b1;
				d_ctx = dc_s0_q;
				d_bit = |dc_abs_q;
				if (adv) begin
					state_d = d_bit ? ST_DC_SIGN : ST_LOAD;
				end
			end
			ST_DC_SIGN: begin
				req   = 1'b1;
				d_ctx = dc_s0_q + pam_pkg::DC_SIGN_OFS;
				d_bit = dc_neg_q;
				if (adv) begin
					sz_d    = dc_abs_q - 17'h1;
					state_d = ST_SZ0;
				end
			end
			ST_DC_REF: begin
				req   = 1'b1;
				d_fix = 1'b1;
				d_bit = dc_ref_q;
				if (adv) begin
					state_d = ST_LOAD;
				end
			end
			ST_EOB: begin
				if (band_done) begin
					state_d = ST_LOAD;
				end else if (is_ref && (k_q < previous_band_end_q)) begin
					state_d = ST_ZSCAN;
				end else begin
					req   = 1'b1;
					d_ctx = se_ctx;
					d_bit = (k_q == eob_q);
					if (adv) begin
						state_d = d_bit ? ST_LOAD : ST_ZSCAN;
					end
				end
			end
			ST_ZSCAN: begin
				req = 1'b1;
				if (is_ref && cur_hist) begin
					d_ctx = se_ctx + pam_pkg::CTX_CORR_OFS;
					d_bit = cur_abs[0];
					if (adv) begin
						k_d     = k_q + 7'h01;
						state_d = ST_EOB;
					end
				end else begin
					d_ctx = se_ctx + pam_pkg::CTX_ZERO_OFS;
					d_bit = |cur_abs;
					if (adv && d_bit) begin
						state_d = ST_SIGN;
					end else if (adv) begin
						k_d = k_q + 7'h01;
					end
				end
			end
			ST_SIGN: begin
				req   = 1'b1;
				d_fix = 1'b1;
				d_bit = cur_sgn;
				if (adv && is_ref) begin
					k_d     = k_q + 7'h01;
					state_d = ST_EOB;
				end else if (adv) begin
					sz_d    = cur_abs - 17'h1;
					state_d = ST_SZ0;
				end
			end
			ST_SZ0: begin
				req   = 1'b1;
				d_ctx = is_dc ? dc_s0_q + dc_sz_ofs : se_ctx + pam_pkg::CTX_SZ_OFS;
				d_bit = |sz_q;
				if (adv && d_bit) begin
					m_d     = 17'h1;
					s_d     = is_dc ? pam_pkg::DC_X1 : x1_ctx;
					state_d = ST_LOG;
				end else if (adv) begin
					state_d = is_dc ? ST_LOAD : ST_EOB;
					k_d     = is_dc ? k_q : k_q + 7'h01;
				end
			end
			ST_LOG: begin
				req   = 1'b1;
				d_ctx = s_q;
				d_bit = sz_ge;
				if (adv && d_bit) begin
					m_d = m_q << 1;
					s_d = s_q + 8'h01;
				end else if (adv) begin
					m_d     = m_q >> 1;
					s_d     = s_q + pam_pkg::MAG_OFS;
					state_d = ST_MAG;
				end
			end
			ST_MAG: begin
				if (m_q == 17'h0) begin
					state_d = is_dc ? ST_LOAD : ST_EOB;
					k_d     = is_dc ? k_q : k_q + 7'h01;
				end else begin
					req   = 1'b1;
					d_ctx = s_q;
					d_bit = |(sz_q & m_q);
					if (adv) begin
						m_d = m_q >> 1;
					end
				end
			end
		endcase
	end

	wire blk_end = (state_q != ST_LOAD) && (state_d == ST_LOAD);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= ST_LOAD;
			k_q        <= 7'h00;
			m_q        <= 17'h0;
			s_q        <= 8'h00;
			sz_q       <= 17'h0;
			coef_ready <= 1'b0;
		end else begin
			state_q    <= state_d;
			k_q        <= k_d;
			m_q        <= m_d;
			s_q        <= s_d;
			sz_q       <= sz_d;
			coef_ready <= (state_d == ST_LOAD);
		end
	end

	// Block bookkeeping and end-of-band tracking while loading
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ld_cnt_q   <= 6'h00;
			eob_q      <= 7'h00;
			previous_band_end_q     <= 7'h00;
			last_eob_q <= 7'h00;
			blk_cnt_q  <= 16'h0;
		end else begin
			if (blk_end) begin
				last_eob_q <= eob_q;
				blk_cnt_q  <= blk_cnt_q + 16'h1;
			end
			if (coef_take && !is_dc) begin
				ld_cnt_q <= ld_last ? 6'h00 : ld_cnt_q + 6'h01;
				if (pt_nz || ld_first) begin
					eob_q <= pt_nz ? ld_k1 : {1'b0, ld_k};
				end
				if (pt_hist || ld_first) begin
					previous_band_end_q <= pt_hist ? ld_k1 : {1'b0, ld_k};
				end
			end
		end
	end

	// DC state per table set, cleared at each restart interval
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pred_q   <= '{default: 16'h0};
			da_ctx_q <= '{default: 8'h00};
			dc_abs_q <= 17'h0;
			dc_neg_q <= 1'b0;
			dc_ref_q <= 1'b0;
			dc_s0_q  <= 8'h00;
		end else begin
			if (restart) begin
				pred_q   <= '{default: 16'h0};
				da_ctx_q <= '{default: 8'h00};
			end
			if (coef_take && is_dc) begin
				pred_q[tbl]   <= dc_pt;
				da_ctx_q[tbl] <= dc_class;
				dc_abs_q      <= dc_dabs;
				dc_neg_q      <= dc_diff[16];
				dc_ref_q      <= dc_pt[0];
				dc_s0_q       <= restart ? 8'h00 : da_ctx_q[tbl];
			end
		end
	end

	// Band storage
	always_ff @(posedge ref_clk) begin
		if (coef_take && !is_dc) begin
			abs_q[ld_k] <= pt_abs;
			sgn_q[ld_k] <= coef_x[16];
		end
	end
endmodule // pam_model

// [include/pam_pkg.sv]
// Overview of operation
// - First DC scan: sequential DC, point transform
// - DC refinement bit uses fixed estimate
// - First AC scan starts band at spectral_start
// - End of band follows last nonzero coefficient
// - split_index_threshold defaults 5, software replaceable
// - Refinement adds one bit per coefficient
// - End decision at start, after nonzero
// - Refinement skips end decision below previous_band_end
// - Skip end decision past last coefficient
// - Zero runs as zero/nonzero decisions
// - New coefficient sign uses fixed estimate
// - Refinement statistics area is 189 bins
// - Bins 3(K-1), plus one, plus two
// - Four conditioning table sets per scan
// - Decisions ordered so decoder mirrors them
package pam_pkg;
	localparam int COEF_W = 16;
	localparam int MAG_W  = 17;
	localparam int CTX_W  = 8;
	localparam int K_W    = 7;
	localparam int IDX_W  = 6;
	localparam int TBL_W  = 2;
	localparam int NUM_TBL = 4;
	localparam int BAND_LEN = 64;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BAND = 8'h04;
	localparam logic [7:0] REG_COND = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam int CTRL_MODE_LO = 0;
	localparam int CTRL_TBL_LO  = 2;
	localparam int CTRL_RESTART = 4;
	localparam int BAND_SS_LO   = 0;
	localparam int BAND_SE_LO   = 8;
	localparam int BAND_AL_LO   = 16;
	localparam int COND_KX_LO   = 0;
	localparam int COND_L_LO    = 8;
	localparam int COND_U_LO    = 12;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_EOB_LO  = 8;
	localparam int STAT_CNT_LO  = 16;
	localparam logic [5:0] KX_RST = 6'h05;
	localparam logic [5:0] SS_RST = 6'h01;
	localparam logic [5:0] SE_RST = 6'h3f;
	localparam logic [3:0] AL_RST = 4'h0;
	localparam logic [3:0] L_RST  = 4'h0;
	localparam logic [3:0] U_RST  = 4'h1;
	localparam logic [7:0] REFINE_BINS    = 8'hbd;
	localparam logic [7:0] AC_X1_LO       = 8'hbd;
	localparam logic [7:0] AC_X1_HI       = 8'hd9;
	localparam logic [7:0] MAG_OFS        = 8'h0e;
	localparam logic [7:0] DC_X1          = 8'h14;
	localparam logic [7:0] CTX_ZERO_OFS   = 8'h01;
	localparam logic [7:0] CTX_CORR_OFS   = 8'h02;
	localparam logic [7:0] CTX_SZ_OFS     = 8'h02;
	localparam logic [7:0] DC_SIGN_OFS    = 8'h01;
	localparam logic [7:0] DC_SZ_POS_OFS  = 8'h02;
	localparam logic [7:0] DC_SZ_NEG_OFS  = 8'h03;
	localparam logic [7:0] DC_S0_ZERO     = 8'h00;
	localparam logic [7:0] DC_S0_SPOS     = 8'h04;
	localparam logic [7:0] DC_S0_SNEG     = 8'h08;
	localparam logic [7:0] DC_S0_LPOS     = 8'h0c;
	localparam logic [7:0] DC_S0_LNEG     = 8'h10;
	localparam logic [15:0] FIXED_QE      = 16'h5a1d;
	localparam logic        FIXED_MPS     = 1'b0;
	typedef enum logic [1:0] {
		PAM_DC_FIRST, PAM_DC_REFINE, PAM_AC_FIRST, PAM_AC_REFINE
	} pam_mode_t;
	typedef enum logic [1:0] {
		PAM_AREA_DC, PAM_AREA_AC, PAM_AREA_ACR, PAM_AREA_FIXED
	} pam_area_t;
endpackage

// [include/pam_dec_if.sv]
`timescale 1ns/1ps
interface pam_dec_if;
	logic                           req;
	logic                           free;
	logic                           fixed;
	logic                           bit_v;
	logic [pam_pkg::CTX_W-1:0]      ctx;
	pam_pkg::pam_area_t             area;
	logic [pam_pkg::TBL_W-1:0]      tbl;
	modport src (output req, fixed, bit_v, ctx, area, tbl, input free);
	modport snk (input req, fixed, bit_v, ctx, area, tbl, output free);
endinterface

// [design/pam_dec_port.sv]
`timescale 1ns/1ps
module pam_dec_port (
	input  wire logic                        ref_clk,   // Clock
	input  wire logic                        rst_b,     // Async reset
	pam_dec_if.snk                           dp,        // Decision from sequencer
	output logic                             dec_valid, // Decision pending
	output logic [pam_pkg::CTX_W-1:0]        dec_ctx,   // Bin index
	output logic                             dec_fixed, // Fixed estimate request
	output logic                             dec_bit,   // Decision value
	output pam_pkg::pam_area_t               dec_area,  // Statistics area
	output logic [pam_pkg::TBL_W-1:0]        dec_table, // Table set
	input  wire logic                        dec_ready  // Engine accepts
);
	assign dp.free = !dec_valid || dec_ready;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dec_valid <= 1'b0;
			dec_ctx   <= '0;
			dec_fixed <= 1'b0;
			dec_bit   <= 1'b0;
			dec_area  <= pam_pkg::PAM_AREA_DC;
			dec_table <= '0;
		end else if (dp.req && dp.free) begin
			dec_valid <= 1'b1;
			dec_ctx   <= dp.ctx;
			dec_fixed <= dp.fixed;
			dec_bit   <= dp.bit_v;
			dec_area  <= dp.area;
			dec_table <= dp.tbl;
		end else if (dec_ready) begin
			dec_valid <= 1'b0;
		end
	end
endmodule // pam_dec_port

// [design/pam_ahb_regs.sv]
`timescale 1ns/1ps
module pam_ahb_regs (
	input  wire logic        ref_clk,   // Clock
	input  wire logic        rst_b,     // Async reset
	input  wire logic        hsel,      // Slave select
	input  wire logic [31:0] haddr,     // Address
	input  wire logic [1:0]  htrans,    // Transfer type
	input  wire logic        hwrite,    // Write
	input  wire logic [2:0]  hsize,     // Size, word only
	input  wire logic [31:0] hwdata,    // Write data
	input  wire logic        hready,    // Bus ready
	output logic [31:0]      hrdata,    // Read data
	output logic             hreadyout, // Slave ready
	output logic             hresp,     // Always OKAY
	output pam_pkg::pam_mode_t mode,    // Scan mode
	output logic [1:0]       tbl,       // Table set
	output logic             restart,   // Restart pulse
	output logic [5:0]       ss,        // spectral_start
	output logic [5:0]       se,        // spectral_end
	output logic [3:0]       al,        // Point transform shift
	output logic [5:0]       kx,        // split_index_threshold
	output logic [3:0]       dc_l,      // DC lower bound
	output logic [3:0]       dc_u,      // DC upper bound
	input  wire logic        busy,      // Block in progress
	input  wire logic [6:0]  last_eob,  // Last end_of_band
	input  wire logic [15:0] blk_cnt    // Blocks coded
);
	logic       wr_pend_q;
	logic [7:0] wr_addr_q;
	wire        ap_take = hsel && hready && htrans[1];
	wire [7:0]  ap_addr = haddr[7:0];
	wire [31:0] ctrl_rd = (32'(mode) << pam_pkg::CTRL_MODE_LO) |
		(32'(tbl) << pam_pkg::CTRL_TBL_LO);
	wire [31:0] band_rd = (32'(ss) << pam_pkg::BAND_SS_LO) |
		(32'(se) << pam_pkg::BAND_SE_LO) | (32'(al) << pam_pkg::BAND_AL_LO);
	wire [31:0] cond_rd = (32'(kx) << pam_pkg::COND_KX_LO) |
		(32'(dc_l) << pam_pkg::COND_L_LO) | (32'(dc_u) << pam_pkg::COND_U_LO);
	wire [31:0] stat_rd = (32'(busy) << pam_pkg::STAT_BUSY) |
		(32'(last_eob) << pam_pkg::STAT_EOB_LO) | (32'(blk_cnt) << pam_pkg::STAT_CNT_LO);
	wire [31:0] rd_val = (ap_addr == pam_pkg::REG_CTRL) ? ctrl_rd :
		(ap_addr == pam_pkg::REG_BAND) ? band_rd :
		(ap_addr == pam_pkg::REG_COND) ? cond_rd :
		(ap_addr == pam_pkg::REG_STAT) ? stat_rd : 32'h0;
	wire wr_ctrl = wr_pend_q && (wr_addr_q == pam_pkg::REG_CTRL);
	wire wr_band = wr_pend_q && (wr_addr_q == pam_pkg::REG_BAND);
	wire wr_cond = wr_pend_q && (wr_addr_q == pam_pkg::REG_COND);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend_q <= ap_take && hwrite;
			wr_addr_q <= ap_addr;
			hrdata    <= (ap_take && !hwrite) ? rd_val : 32'h0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode    <= pam_pkg::PAM_DC_FIRST;
			tbl     <= 2'h0;
			restart <= 1'b0;
			ss      <= pam_pkg::SS_RST;
			se      <= pam_pkg::SE_RST;
			al      <= pam_pkg::AL_RST;
			kx      <= pam_pkg::KX_RST;
			dc_l    <= pam_pkg::L_RST;
			dc_u    <= pam_pkg::U_RST;
		end else begin
			restart <= wr_ctrl && hwdata[pam_pkg::CTRL_RESTART];
			if (wr_ctrl) begin
				mode <= pam_pkg::pam_mode_t'(hwdata[pam_pkg::CTRL_MODE_LO +: 2]);
				tbl  <= hwdata[pam_pkg::CTRL_TBL_LO +: 2];
			end
			if (wr_band) begin
				ss <= hwdata[pam_pkg::BAND_SS_LO +: 6];
				se <= hwdata[pam_pkg::BAND_SE_LO +: 6];
				al <= hwdata[pam_pkg::BAND_AL_LO +: 4];
			end
			if (wr_cond) begin
				kx   <= hwdata[pam_pkg::COND_KX_LO +: 6];
				dc_l <= hwdata[pam_pkg::COND_L_LO +: 4];
				dc_u <= hwdata[pam_pkg::COND_U_LO +: 4];
			end
		end
	end
endmodule // pam_ahb_regs

// [verification/pam_model_monitor.sv]
`timescale 1ns/1ps
module pam_model_monitor (
	input wire logic               ref_clk,    // Clock
	input wire logic               rst_b,      // Reset
	input wire logic               hsel,       // Select
	input wire logic [1:0]         htrans,     // Transfer
	input wire logic               hwrite,     // Write
	input wire logic               hready,     // Ready in
	input wire logic [31:0]        hrdata,     // Read data
	input wire logic               hreadyout,  // Ready out
	input wire logic               hresp,      // Response
	input wire logic               coef_ready, // Taking
	input wire logic               dec_valid,  // Pending
	input wire logic [7:0]         dec_ctx,    // Bin
	input wire logic               dec_fixed,  // Fixed
	input wire logic               dec_bit,    // Value
	input wire pam_pkg::pam_area_t dec_area,   // Area
	input wire logic [1:0]         dec_table,  // Table
	input wire logic               dec_ready   // Accept
);
	default clocking mon_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	dec_hold_a: assert property (dec_valid && !dec_ready |=> dec_valid
		&& $stable({dec_ctx, dec_fixed, dec_bit, dec_area, dec_table}))
		else $error("decision changed before acceptance");
	dec_drop_a: assert property ($fell(dec_valid) |-> $past(dec_ready))
		else $error("decision withdrawn without acceptance");
	fixed_ctx_a: assert property (dec_valid && dec_fixed |->
		dec_ctx == 8'h00 && dec_area == pam_pkg::PAM_AREA_FIXED)
		else $error("fixed request with bin or area set");
	fixed_area_a: assert property (dec_valid && dec_area == pam_pkg::PAM_AREA_FIXED |-> dec_fixed)
		else $error("fixed area without fixed request");
	refine_bins_a: assert property (dec_valid && dec_area == pam_pkg::PAM_AREA_ACR |->
		dec_ctx < 8'hbd)
		else $error("refinement bin outside area");
	first_dec_a: assert property ($fell(coef_ready) |-> ##[0:4] dec_valid)
		else $error("no decision after block loaded");
	bus_ok_a: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
	idle_rd_a: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
		else $error("read data outside data phase");
endmodule // pam_model_monitor

bind pam_model pam_model_monitor i_pam_model_monitor (
	.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.coef_ready(coef_ready), .dec_valid(dec_valid), .dec_ctx(dec_ctx),
	.dec_fixed(dec_fixed), .dec_bit(dec_bit), .dec_area(dec_area),
	.dec_table(dec_table), .dec_ready(dec_ready)
);

// [verification/pam_eng_model.sv]
`timescale 1ns/1ps
module pam_eng_model (
	input wire logic               ref_clk,   // Clock
	input wire logic               rst_b,     // Reset
	input wire logic               slow,      // Stall alternate cycles
	input wire logic               dec_valid, // Pending
	input wire logic [7:0]         dec_ctx,   // Bin
	input wire logic               dec_fixed, // Fixed
	input wire logic               dec_bit,   // Value
	input wire pam_pkg::pam_area_t dec_area,  // Area
	input wire logic [1:0]         dec_table, // Table
	output logic                   dec_ready  // Accept
);
	logic [13:0] log_q[$];
	logic [15:0] qe;
	int          hits [4][256];

	// Fixed half estimate bypasses the bins
	assign qe = dec_fixed ? pam_pkg::FIXED_QE : 16'h5601;

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dec_ready <= 1'b0;
		end else begin
			dec_ready <= slow ? !dec_ready : 1'b1;
			if (dec_valid && dec_ready) begin
				log_q.push_back({dec_fixed, dec_area, dec_table, dec_ctx, dec_bit});
				if (!dec_fixed)
					hits[dec_table][dec_ctx] <= hits[dec_table][dec_ctx] + 1;
			end
		end
	end
endmodule // pam_eng_model

// [verification/progressive_arith_sa_model_tb.sv]
`timescale 1ns/1ps
module progressive_arith_sa_model_tb;
	localparam logic [1:0] A_AC = pam_pkg::PAM_AREA_AC;
	localparam logic [1:0] A_RF = pam_pkg::PAM_AREA_ACR;
	localparam logic [1:0] A_FX = pam_pkg::PAM_AREA_FIXED;
	logic               ref_clk    = 1'b0;
	logic               rst_b      = 1'b0;
	logic               hsel       = 1'b0;
	logic [31:0]        haddr      = 32'h0;
	logic [1:0]         htrans     = 2'h0;
	logic               hwrite     = 1'b0;
	logic [2:0]         hsize      = 3'h2;
	logic [31:0]        hwdata     = 32'h0;
	logic               coef_valid = 1'b0;
	logic [15:0]        coef_data  = 16'h0;
	logic               slow       = 1'b0;
	logic [31:0]        hrdata;
	logic               hreadyout;
	logic               hresp;
	logic               coef_ready;
	logic               dec_valid;
	logic               dec_fixed;
	logic               dec_bit;
	logic               dec_ready;
	logic [7:0]         dec_ctx;
	logic [1:0]         dec_table;
	pam_pkg::pam_area_t dec_area;
	logic [15:0]        vals [3] = '{16'h0001, 16'hffff, 16'h0000};
	int                 err_count = 0;
	int                 n_checks  = 0;

	always #25 ref_clk = ~ref_clk;

	pam_model i_pam_model (
		.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .coef_valid(coef_valid),
		.coef_data(coef_data), .coef_ready(coef_ready), .dec_valid(dec_valid),
		.dec_ctx(dec_ctx), .dec_fixed(dec_fixed), .dec_bit(dec_bit), .dec_area(dec_area),
		.dec_table(dec_table), .dec_ready(dec_ready)
	);

	pam_eng_model i_pam_eng_model (
		.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow), .dec_valid(dec_valid),
		.dec_ctx(dec_ctx), .dec_fixed(dec_fixed), .dec_bit(dec_bit), .dec_area(dec_area),
		.dec_table(dec_table), .dec_ready(dec_ready)
	);

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do
			@(posedge ref_clk);
		while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do
			@(posedge ref_clk);
		while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Configuration only moves between blocks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		while (coef_ready !== 1'b1)
			@(posedge ref_clk);
		bus(1'b1, a, d, rd);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		cmp(rd, exp);
	endtask

	task automatic put(input logic [15:0] v, input logic last);
		coef_valid <= 1'b1;
		coef_data  <= v;
		do
			@(posedge ref_clk);
		while (coef_ready !== 1'b1);
		if (last)
			coef_valid <= 1'b0;
	endtask

	task automatic dec(input logic f, input logic [1:0] ar, input logic [1:0] t,
			input logic [7:0] c, input logic b);
		while (i_pam_eng_model.log_q.size() == 0)
			@(posedge ref_clk);
		cmp({18'h0, i_pam_eng_model.log_q.pop_front()}, {18'h0, f, ar, t, c, b});
	endtask

	task automatic wrap_up;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#(50 * 20000);
		err_count++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		rdc(pam_pkg::REG_CTRL, 32'h00000000);
		rdc(pam_pkg::REG_BAND, 32'h00003f01);
		rdc(pam_pkg::REG_COND, 32'h00001005);
		rdc(8'h10, 32'h00000000);
		wr(pam_pkg::REG_COND, 32'h0000100a);
		rdc(pam_pkg::REG_COND, 32'h0000100a);
		wr(pam_pkg::REG_COND, 32'h00001001);
		// First AC scan, one-coefficient band, engine stalling
		wr(pam_pkg::REG_BAND, 32'h00000101);
		wr(pam_pkg::REG_CTRL, 32'h00000002);
		slow <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			put(vals[i], 1'b1);
			if (i < 2) begin
				dec(1'b0, A_AC, 2'h0, 8'h00, 1'b0);
				dec(1'b0, A_AC, 2'h0, 8'h01, 1'b1);
				dec(1'b1, A_FX, 2'h0, 8'h00, i[0]);
				dec(1'b0, A_AC, 2'h0, 8'h02, 1'b0);
			end else
				dec(1'b0, A_AC, 2'h0, 8'h00, 1'b1);
		end
		// DC refinement, shift one, table set three
		wr(pam_pkg::REG_BAND, 32'h00010101);
		wr(pam_pkg::REG_CTRL, 32'h0000000d);
		put(16'h0006, 1'b1);
		dec(1'b1, A_FX, 2'h3, 8'h00, 1'b1);
		put(16'h0004, 1'b1);
		dec(1'b1, A_FX, 2'h3, 8'h00, 1'b0);
		// AC refinement: new coefficient, then one with history
		slow <= 1'b0;
		wr(pam_pkg::REG_BAND, 32'h00000201);
		wr(pam_pkg::REG_CTRL, 32'h00000003);
		put(16'h0001, 1'b0);
		put(16'h0000, 1'b1);
		dec(1'b0, A_RF, 2'h0, 8'h00, 1'b0);
		dec(1'b0, A_RF, 2'h0, 8'h01, 1'b1);
		dec(1'b1, A_FX, 2'h0, 8'h00, 1'b0);
		dec(1'b0, A_RF, 2'h0, 8'h03, 1'b1);
		put(16'h0002, 1'b0);
		put(16'h0000, 1'b1);
		dec(1'b0, A_RF, 2'h0, 8'h02, 1'b0);
		dec(1'b0, A_RF, 2'h0, 8'h03, 1'b1);
		wr(pam_pkg::REG_CTRL, 32'h00000013);
		rdc(pam_pkg::REG_CTRL, 32'h00000003);
		rdc(pam_pkg::REG_STAT, 32'h00070200);
		// DC first after restart: small, then large negative difference
		wr(pam_pkg::REG_CTRL, 32'h00000010);
		put(16'h0001, 1'b1);
		dec(1'b0, 2'h0, 2'h0, 8'h00, 1'b1);
		dec(1'b0, 2'h0, 2'h0, 8'h01, 1'b0);
		dec(1'b0, 2'h0, 2'h0, 8'h02, 1'b0);
		put(16'hfffd, 1'b1);
		dec(1'b0, 2'h0, 2'h0, 8'h04, 1'b1);
		dec(1'b0, 2'h0, 2'h0, 8'h05, 1'b1);
		dec(1'b0, 2'h0, 2'h0, 8'h07, 1'b1);
		dec(1'b0, 2'h0, 2'h0, 8'h14, 1'b1);
		dec(1'b0, 2'h0, 2'h0, 8'h15, 1'b0);
		dec(1'b0, 2'h0, 2'h0, 8'h23, 1'b1);
		repeat (4) @(posedge ref_clk);
		cmp(i_pam_eng_model.log_q.size(), 32'h0);
		wrap_up();
	end
endmodule // progressive_arith_sa_model_tb
